// File: verilog/asf_pkg.sv
// Shared constants, operation codes and flag-mask decode for the ALU flag block.
// Assumes a single 40 MHz core clock and an AHB-Lite register port.
package asf_pkg;

	// ************************************************************
	// Flag layout
	// ************************************************************
	localparam int        FLAG_W         = 5;      // Implemented flag bits
	localparam int        FLAG_NEG_BIT   = 4;      // Negative
	localparam int        FLAG_OVF_BIT   = 3;      // Signed overflow
	localparam int        FLAG_ZERO_BIT  = 2;      // Zero
	localparam int        FLAG_DIG_BIT   = 1;      // Digit carry / borrow
	localparam int        FLAG_CARRY_BIT = 0;      // Carry / borrow
	localparam int        DATA_MSB       = 7;      // Sign bit of a byte
	localparam int        NIBBLE_W       = 4;      // Low nibble width
	localparam logic [7:0] FLAGS_IMPL    = 8'h1F;  // Upper three bits unimplemented
	localparam logic [7:0] FLAGS_RESET   = 8'h00;  // Defined value after reset

	// Which flags each class of operation updates
	localparam logic [4:0] MASK_NONE  = 5'h00;
	localparam logic [4:0] MASK_ARITH = 5'h1F;     // N OV Z DC C
	localparam logic [4:0] MASK_ROT   = 5'h17;     // N Z DC C
	localparam logic [4:0] MASK_LOGIC = 5'h14;     // N Z
	localparam logic [4:0] MASK_CLEAR = 5'h04;     // Z only

	// ************************************************************
	// Register map and bus encodings
	// ************************************************************
	localparam int        ADDR_W            = 8;     // Decoded low address bits
	localparam logic [7:0] REG_FLAGS_ADDR   = 8'h00; // alu_flags
	localparam logic [7:0] REG_RESULT_ADDR  = 8'h04; // Last ALU result, read only
	localparam int        HTRANS_ACTIVE_BIT = 1;     // NONSEQ or SEQ
	localparam logic      HRESP_OKAY        = 1'h0;

	// ************************************************************
	// Operations issued by the execution logic
	// ************************************************************
	typedef enum logic [3:0] {
		OP_ADD_FILE, OP_ADD_LIT, OP_SUB_LIT, OP_SUB_FILE,
		OP_ROT_RIGHT, OP_ROT_LEFT, OP_CLEAR_FILE,
		OP_BIT_CLEAR, OP_BIT_SET, OP_NIBBLE_SWAP,
		OP_MOVE_FF, OP_MOVE_WF, OP_AND, OP_IOR, OP_XOR
	} asf_op_t;

	// Flags touched by an operation
	function automatic logic [4:0] asf_flag_mask(input asf_op_t op);
		case (op)
			OP_ADD_FILE, OP_ADD_LIT, OP_SUB_LIT, OP_SUB_FILE: asf_flag_mask = MASK_ARITH;
			OP_ROT_RIGHT, OP_ROT_LEFT:                        asf_flag_mask = MASK_ROT;
			OP_AND, OP_IOR, OP_XOR:                           asf_flag_mask = MASK_LOGIC;
			OP_CLEAR_FILE:                                    asf_flag_mask = MASK_CLEAR;
			default:                                          asf_flag_mask = MASK_NONE;
		endcase
	endfunction

endpackage

// File: verilog/asf_alu_if.sv
// Bundle between the flag register block and its combinational ALU.
// Assumes both ends sit in the core clock domain.
`timescale 1ns/10ps
interface asf_alu_if;
	import asf_pkg::*;
	asf_op_t    op;        // Operation
	logic [7:0] wreg;      // Working register operand
	logic [7:0] fileOp;    // File or literal operand
	logic [2:0] bitSel;    // Bit index for bit set and clear
	logic       carryIn;   // Current carry for rotates
	logic [7:0] result;    // Byte result
	logic [4:0] newFlags;  // Flag values from the result
	logic [4:0] flagMask;  // Flags this operation owns

	modport calc (input op, wreg, fileOp, bitSel, carryIn, output result, newFlags, flagMask);
	modport core (output op, wreg, fileOp, bitSel, carryIn, input result, newFlags, flagMask);
endinterface

// File: verilog/asf_alu_calc.sv
// Combinational ALU: byte result plus the five flags it produces.
// Assumes the caller registers everything; no state lives here.
`timescale 1ns/10ps
module asf_alu_calc
	import asf_pkg::*;
(
	asf_alu_if.calc alu  // Operand and result bundle
);

	logic [8:0] sumFull;  // Byte sum with carry out
	logic [4:0] sumNib;   // Low nibble sum with digit carry
	logic [7:0] addend;   // Second operand, inverted for subtraction
	logic [7:0] minuend;  // First operand
	logic       isSub;    // Subtraction in progress
	logic       isRot;    // Rotate in progress

	// ************************************************************
	// Result and flag derivation
	// ************************************************************
	always_comb begin
		isSub   = (alu.op == OP_SUB_LIT) || (alu.op == OP_SUB_FILE);
		isRot   = (alu.op == OP_ROT_RIGHT) || (alu.op == OP_ROT_LEFT);
		minuend = isSub ? alu.fileOp : alu.wreg;
		// Subtract by adding the two's complement, so carry means no borrow
		addend  = isSub ? ~alu.wreg : alu.fileOp;
		sumFull = {1'h0, minuend} + {1'h0, addend} + {8'h00, isSub};
		sumNib  = {1'h0, minuend[NIBBLE_W-1:0]} + {1'h0, addend[NIBBLE_W-1:0]} + {4'h0, isSub};
		case (alu.op)
			OP_ADD_FILE, OP_ADD_LIT, OP_SUB_LIT, OP_SUB_FILE: alu.result = sumFull[7:0];
			OP_ROT_RIGHT:   alu.result = {alu.carryIn, alu.fileOp[7:1]};
			OP_ROT_LEFT:    alu.result = {alu.fileOp[6:0], alu.carryIn};
			OP_CLEAR_FILE:  alu.result = 8'h00;
			OP_BIT_CLEAR:   alu.result = alu.fileOp & ~(8'h01 << alu.bitSel);
			OP_BIT_SET:     alu.result = alu.fileOp | (8'h01 << alu.bitSel);
			OP_NIBBLE_SWAP: alu.result = {alu.fileOp[3:0], alu.fileOp[7:4]};
			OP_MOVE_WF:     alu.result = alu.wreg;
			OP_AND:         alu.result = alu.wreg & alu.fileOp;
			OP_IOR:         alu.result = alu.wreg | alu.fileOp;
			OP_XOR:         alu.result = alu.wreg ^ alu.fileOp;
			default:        alu.result = alu.fileOp;  // File to file move
		endcase
		alu.flagMask = asf_flag_mask(alu.op);
		alu.newFlags = '0;
		alu.newFlags[FLAG_NEG_BIT]  = alu.result[DATA_MSB];
		alu.newFlags[FLAG_ZERO_BIT] = (alu.result == 8'h00);
		// Sign flips although both operands agree in sign
		alu.newFlags[FLAG_OVF_BIT]  = (minuend[DATA_MSB] == addend[DATA_MSB]) &&
			(sumFull[DATA_MSB] != minuend[DATA_MSB]);
		if (isRot) begin
			// Bit crossing the nibble boundary goes to digit carry
			alu.newFlags[FLAG_DIG_BIT]   = (alu.op == OP_ROT_RIGHT) ? alu.fileOp[4]
				: alu.fileOp[3];
			alu.newFlags[FLAG_CARRY_BIT] = (alu.op == OP_ROT_RIGHT) ? alu.fileOp[0]
				: alu.fileOp[DATA_MSB];
		end else begin
			alu.newFlags[FLAG_DIG_BIT]   = sumNib[NIBBLE_W];
			alu.newFlags[FLAG_CARRY_BIT] = sumFull[8];
		end
	end

endmodule

// File: verilog/alu_status_flags.sv
// Arithmetic flag register of the core with its ALU and an AHB-Lite register port.
// Assumes the execution logic issues one instruction per valid pulse, same clock.
`timescale 1ns/10ps
module alu_status_flags
	import asf_pkg::*;
(
	input  wire logic        core_clk,       // Core clock, 40 MHz
	input  wire logic        rst_n,          // Asynchronous reset, active low
	input  wire logic        hsel,           // AHB slave select
	input  wire logic [31:0] haddr,          // AHB address
	input  wire logic [1:0]  htrans,         // AHB transfer type
	input  wire logic        hwrite,         // AHB write strobe
	input  wire logic [2:0]  hsize,          // AHB size, word only
	input  wire logic [31:0] hwdata,         // AHB write data
	input  wire logic        hready,         // AHB bus ready
	output logic      [31:0] hrdata_ff,      // AHB read data
	output logic             hreadyout_ff,   // AHB slave ready
	output logic             hresp_ff,       // AHB response, always OKAY
	input  wire logic        instrValid,     // Instruction executes this cycle
	input  wire asf_op_t     instrOp,        // Operation of the instruction
	input  wire logic [7:0]  wregVal,        // Working register value
	input  wire logic [7:0]  fileVal,        // File register or literal value
	input  wire logic [2:0]  bitSel,         // Bit index for bit ops
	input  wire logic        srcIsFlags,     // File operand is the flag register
	input  wire logic        destIsFlags,    // Destination is the flag register
	output logic      [7:0]  aluFlags_ff,    // Flag register contents
	output logic      [7:0]  resultData_ff,  // Last result byte
	output logic             resultValid_ff  // Result written this cycle
);

	// ************************************************************
	// Declarations
	// ************************************************************
	asf_alu_if aluBus ();                       // Bundle to the ALU

	logic             wrPend_ff;              // Write data phase pending
	logic [ADDR_W-1:0] wrAddr_ff;              // Address of pending write
	logic             busAccept;              // Address phase taken
	logic             flagsBusWr;             // Software writes alu_flags now
	logic [7:0]       operandB;               // File operand after source mux
	logic [7:0]       dataBase;               // Byte before flag logic
	logic [7:0]       nxt_aluFlags;           // Next flag register value
	logic [7:0]       readMux;                // Read data for the address phase

	// ************************************************************
	// Operand routing into the ALU
	// ************************************************************
	// Flag register may feed the file operand like any register
	always_comb begin
		operandB = srcIsFlags ? aluFlags_ff : fileVal;
	end

	assign aluBus.op      = instrOp;
	assign aluBus.wreg    = wregVal;
	assign aluBus.fileOp  = operandB;
	assign aluBus.bitSel  = bitSel;
	assign aluBus.carryIn = aluFlags_ff[FLAG_CARRY_BIT];

	asf_alu_calc u_calc (
		.alu (aluBus.calc)
	);

	// ************************************************************
	// AHB-Lite slave
	// ************************************************************
	// Zero wait states: every transfer completes in its first data phase
	always_comb begin
		busAccept  = hsel && htrans[HTRANS_ACTIVE_BIT] && hready;
		flagsBusWr = wrPend_ff && (wrAddr_ff == REG_FLAGS_ADDR);
		case (haddr[ADDR_W-1:0])
			REG_FLAGS_ADDR:  readMux = aluFlags_ff;
			REG_RESULT_ADDR: readMux = resultData_ff;
			default:         readMux = 8'h00;  // Unmapped reads return zero
		endcase
	end

	// Capture write address phase; data arrives next cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wrPend_ff <= 1'h0;
			wrAddr_ff <= '0;
		end else begin
			wrPend_ff <= busAccept && hwrite;
			if (busAccept && hwrite) begin
				wrAddr_ff <= haddr[ADDR_W-1:0];
			end
		end
	end

	// Read data sampled at the address phase, shown in the data phase
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hrdata_ff <= '0;
		end else if (busAccept && !hwrite) begin
			hrdata_ff <= {24'h000000, readMux};
		end
	end

	// Ready and response are constant; kept as flops for clean outputs
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hreadyout_ff <= 1'h1;
			hresp_ff     <= HRESP_OKAY;
		end else begin
			hreadyout_ff <= 1'h1;
			hresp_ff     <= HRESP_OKAY;
		end
	end

	// ************************************************************
	// Flag register update
	// ************************************************************
	// Instruction beats a software write in the same cycle; the core owns the flags
	always_comb begin
		nxt_aluFlags = aluFlags_ff;
		dataBase     = aluFlags_ff;
		if (flagsBusWr) begin
			nxt_aluFlags = hwdata[7:0] & FLAGS_IMPL;
		end
		if (instrValid) begin
			if (destIsFlags && (aluBus.flagMask == MASK_NONE)) begin
				dataBase = aluBus.result;
			end else if (destIsFlags) begin
				// Data write to all five flags blocked; clear ends as 000u u1uu
				dataBase = aluFlags_ff;
			end
			nxt_aluFlags = dataBase & FLAGS_IMPL;
			nxt_aluFlags[FLAG_W-1:0] = (dataBase[FLAG_W-1:0] & ~aluBus.flagMask) |
				(aluBus.newFlags & aluBus.flagMask);
		end
	end

	// Flags settle at the end of the instruction, seen by the next one
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			aluFlags_ff <= FLAGS_RESET;
		end else begin
			aluFlags_ff <= nxt_aluFlags;
		end
	end

	// ************************************************************
	// Result register
	// ************************************************************
	// Result byte and its strobe, same edge as the flags
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			resultData_ff  <= 8'h00;
			resultValid_ff <= 1'h0;
		end else begin
			resultValid_ff <= instrValid;
			if (instrValid) begin
				resultData_ff <= aluBus.result;
			end
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	logic [8:0] chkSum;   // Reference unsigned sum
	logic [4:0] chkNib;   // Reference nibble sum
	logic       chkKeep;  // Instruction that must keep all flags

	always_comb begin
		chkSum  = {1'h0, wregVal} + {1'h0, operandB};
		chkNib  = {1'h0, wregVal[3:0]} + {1'h0, operandB[3:0]};
		chkKeep = instrValid && !destIsFlags && !flagsBusWr &&
			(instrOp inside {OP_BIT_CLEAR, OP_BIT_SET, OP_NIBBLE_SWAP, OP_MOVE_FF, OP_MOVE_WF});
	end

	property p_src_flags;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && srcIsFlags && (instrOp == OP_MOVE_FF) |=> resultData_ff == $past(aluFlags_ff);
	endproperty
	a_src_flags: assert property (p_src_flags) else $error("flag source not read");

	property p_dest_block;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && destIsFlags && (aluBus.flagMask != MASK_NONE) && !flagsBusWr
			|=> ((aluFlags_ff ^ $past(aluFlags_ff)) & {3'h0, ~$past(aluBus.flagMask)}) == 8'h00;
	endproperty
	a_dest_block: assert property (p_dest_block) else $error("flag data write leaked");

	property p_clear_flags;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && destIsFlags && (instrOp == OP_CLEAR_FILE)
			|=> aluFlags_ff == ($past(aluFlags_ff) | 8'h04);
	endproperty
	a_clear_flags: assert property (p_clear_flags) else $error("clear on flags wrong");

	property p_keep_flags;
		@(posedge core_clk) disable iff (!rst_n)
		chkKeep |=> $stable(aluFlags_ff);
	endproperty
	a_keep_flags: assert property (p_keep_flags) else $error("flags changed by move or bit op");

	property p_upper_zero;
		@(posedge core_clk) disable iff (!rst_n)
		flagsBusWr || instrValid |=> aluFlags_ff[7:5] == 3'h0 ##1 aluFlags_ff[7:5] == 3'h0;
	endproperty
	a_upper_zero: assert property (p_upper_zero) else $error("upper flag bits set");

	property p_negative;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && !destIsFlags && (instrOp == OP_AND)
			|=> aluFlags_ff[FLAG_NEG_BIT] == resultData_ff[DATA_MSB];
	endproperty
	a_negative: assert property (p_negative) else $error("negative flag mismatch");

	property p_overflow;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && (instrOp == OP_ADD_LIT)
			|=> aluFlags_ff[FLAG_OVF_BIT] == (($past(wregVal[7]) == $past(operandB[7])) &&
				(resultData_ff[7] != $past(wregVal[7])));
	endproperty
	a_overflow: assert property (p_overflow) else $error("overflow flag mismatch");

	property p_zero;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && (instrOp == OP_XOR) |=> aluFlags_ff[FLAG_ZERO_BIT] == (resultData_ff == 8'h00);
	endproperty
	a_zero: assert property (p_zero) else $error("zero flag mismatch");

	property p_digit;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && (instrOp == OP_ADD_FILE) |=> aluFlags_ff[FLAG_DIG_BIT] == $past(chkNib[4]);
	endproperty
	a_digit: assert property (p_digit) else $error("digit carry mismatch");

	property p_carry;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && (instrOp == OP_ADD_FILE) |=> aluFlags_ff[FLAG_CARRY_BIT] == $past(chkSum[8]);
	endproperty
	a_carry: assert property (p_carry) else $error("carry mismatch");

	property p_borrow;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && (instrOp == OP_SUB_FILE)
			|=> aluFlags_ff[FLAG_CARRY_BIT] == ($past(operandB) >= $past(wregVal));
	endproperty
	a_borrow: assert property (p_borrow) else $error("borrow polarity wrong");

	property p_rot_carry;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && (instrOp == OP_ROT_RIGHT) |=> aluFlags_ff[FLAG_CARRY_BIT] == $past(operandB[0])
			&& resultData_ff[7] == $past(aluFlags_ff[0]);
	endproperty
	a_rot_carry: assert property (p_rot_carry) else $error("rotate carry wrong");

	property p_rot_digit;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid && (instrOp == OP_ROT_LEFT) |=> aluFlags_ff[FLAG_DIG_BIT] == $past(operandB[3]);
	endproperty
	a_rot_digit: assert property (p_rot_digit) else $error("rotate digit carry wrong");

	property p_same_edge;
		@(posedge core_clk) disable iff (!rst_n)
		instrValid ##1 !instrValid |-> resultValid_ff ##1 !resultValid_ff;
	endproperty
	a_same_edge: assert property (p_same_edge) else $error("result strobe late");

endmodule

// File: dv/alu_status_flags_tb.sv
// Self-checking bench for the ALU flag register: AHB-Lite register tasks plus instruction tasks.
// Assumes the package constants, a single 40 MHz clock and zero-wait slave answers.
`timescale 1ns/10ps
module alu_status_flags_tb
	import asf_pkg::*;
;
	// ************************************************************
	// Signals
	// ************************************************************
	logic        core_clk;     // Core clock
	logic        rst_n;        // Reset, active low
	logic        hsel;         // Slave select
	logic [31:0] haddr;        // Bus address
	logic [1:0]  htrans;       // Transfer type
	logic        hwrite;       // Write strobe
	logic [2:0]  hsize;        // Always a word
	logic [31:0] hwdata;       // Write data
	wire  [31:0] hrdata;       // Read data
	wire         hreadyout;    // Slave ready, also bus ready
	wire         hresp;        // Response
	logic        instrValid;   // Instruction strobe
	asf_op_t     instrOp;      // Operation
	logic [7:0]  wregVal;      // Working operand
	logic [7:0]  fileVal;      // File operand
	logic [2:0]  bitSel;       // Bit index
	logic        srcIsFlags;   // Source is flag register
	logic        destIsFlags;  // Destination is flag register
	wire  [7:0]  aluFlags;     // Flag register
	wire  [7:0]  resultData;   // Last result
	wire         resultValid;  // Result strobe
	int          failures;     // Mismatches
	int          num_checks;   // Comparisons
	logic [7:0]  expFlags;     // Predicted flag register
	logic [7:0]  expResult;    // Predicted result
	logic [31:0] rdata;        // Scratch read data
	asf_op_t     arithOps[4] = '{OP_ADD_FILE, OP_ADD_LIT, OP_SUB_LIT, OP_SUB_FILE};
	logic [15:0] pairs[6] = '{16'h7F01, 16'hFF01, 16'h1001, 16'h0001, 16'h8001, 16'h3CC4};

	alu_status_flags dut_u (
		.core_clk       (core_clk),
		.rst_n          (rst_n),
		.hsel           (hsel),
		.haddr          (haddr),
		.htrans         (htrans),
		.hwrite         (hwrite),
		.hsize          (hsize),
		.hwdata         (hwdata),
		.hready         (hreadyout),
		.hrdata_ff      (hrdata),
		.hreadyout_ff   (hreadyout),
		.hresp_ff       (hresp),
		.instrValid     (instrValid),
		.instrOp        (instrOp),
		.wregVal        (wregVal),
		.fileVal        (fileVal),
		.bitSel         (bitSel),
		.srcIsFlags     (srcIsFlags),
		.destIsFlags    (destIsFlags),
		.aluFlags_ff    (aluFlags),
		.resultData_ff  (resultData),
		.resultValid_ff (resultValid)
	);

	// Free-running clock, 25 ns period
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ************************************************************
	// Helpers
	// ************************************************************
	// Reference flags and result; kept apart from the design's own decode
	function automatic logic [12:0] model(input asf_op_t op, input logic [7:0] w, f, fl,
		input logic [2:0] b, input logic dst);
		logic [8:0] s;
		logic [4:0] lo, m, nf;
		logic [7:0] r;
		logic       ov, dc, c;
		s = {1'b0, f} + {1'b0, w};
		lo = {1'b0, f[3:0]} + {1'b0, w[3:0]};
		ov = (f[7] == w[7]) && (s[7] != f[7]);
		dc = 1'b0;
		c = 1'b0;
		m = MASK_NONE;
		case (op)
			OP_ADD_FILE, OP_ADD_LIT: m = MASK_ARITH;
			OP_SUB_LIT, OP_SUB_FILE: begin
				// Subtract as add of the complement, so carry means no borrow
				s = {1'b0, f} + {1'b0, ~w} + 9'h001;
				lo = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'h01;
				ov = (f[7] != w[7]) && (s[7] != f[7]);
				m = MASK_ARITH;
			end
			OP_ROT_RIGHT: begin
				r = {fl[0], f[7:1]};
				{c, dc, m} = {f[0], f[4], MASK_ROT};
			end
			OP_ROT_LEFT: begin
				r = {f[6:0], fl[0]};
				{c, dc, m} = {f[7], f[3], MASK_ROT};
			end
			OP_AND: {r, m} = {w & f, MASK_LOGIC};
			OP_IOR: {r, m} = {w | f, MASK_LOGIC};
			OP_XOR: {r, m} = {w ^ f, MASK_LOGIC};
			OP_CLEAR_FILE: {r, m} = {8'h00, MASK_CLEAR};
			OP_BIT_CLEAR: r = f & ~(8'h01 << b);
			OP_BIT_SET: r = f | (8'h01 << b);
			OP_NIBBLE_SWAP: r = {f[3:0], f[7:4]};
			OP_MOVE_FF: r = f;
			default: r = w;
		endcase
		if (m == MASK_ARITH) begin
			{r, c, dc} = {s[7:0], s[8], lo[4]};
		end
		nf = {r[7], ov, r == 8'h00, dc, c};
		// Flag-owning ops keep their bits even when the data targets the flags
		if (m == MASK_NONE)
			nf = dst ? r[4:0] : fl[4:0];
		else
			nf = (fl[4:0] & ~m) | (nf & m);
		return {r, nf};
	endfunction

	task automatic check(input logic [31:0] got, exp, input string what);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wrap_up;
		$display("Counts: %0d checks, %0d failures", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Bounded wait for hready sampled high at a rising edge
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1) begin
			failures++;
			$display("CHECK FAILED at %0t: bus wait timed out", $time);
			wrap_up();
		end
	endtask

	// One single AHB-Lite word transfer; read data taken at the closing edge
	task automatic bus(input logic wr, input logic [31:0] addr, wd, output logic [31:0] rd);
		@(posedge core_clk);
		{hsel, haddr, hwrite, htrans} <= {1'b1, addr, wr, 2'b10};
		wait_ready();
		{hsel, htrans, hwdata} <= {1'b0, 2'b00, wd};
		wait_ready();
		rd = hrdata;
		check({31'h0, hresp}, {31'h0, HRESP_OKAY}, "response");
	endtask

	task automatic wr_flags(input logic [7:0] v);
		bus(1'b1, {24'h0, REG_FLAGS_ADDR}, {24'h0, v}, rdata);
		expFlags = v & FLAGS_IMPL;
	endtask

	// Drive one instruction; the strobe is left high for back-to-back use
	task automatic issue(input asf_op_t op, input logic [7:0] w, f, input logic [2:0] b,
		input logic src, dst);
		@(posedge core_clk);
		{instrValid, instrOp, wregVal, fileVal} <= {1'b1, op, w, f};
		{bitSel, srcIsFlags, destIsFlags} <= {b, src, dst};
		{expResult, expFlags[4:0]} = model(op, w, src ? expFlags : f, expFlags, b, dst);
	endtask

	// Close the instruction stream and compare what the last edge produced
	task automatic settle;
		@(posedge core_clk);
		instrValid <= 1'b0;
		#1;
		check({31'h0, resultValid}, 32'h1, "result strobe");
		check({24'h0, resultData}, {24'h0, expResult}, "result");
		check({24'h0, aluFlags}, {24'h0, expFlags}, "flags");
	endtask

	task automatic run(input asf_op_t op, input logic [7:0] w, f, input logic [2:0] b,
		input logic src, dst);
		issue(op, w, f, b, src, dst);
		settle();
	endtask

	// ************************************************************
	// Main sequence
	// ************************************************************
	initial begin
		{failures, num_checks, expFlags, expResult} = '0;
		{rst_n, hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b0, 1'b0, 32'h0, 2'h0, 1'b0, 3'h2, 32'h0};
		{instrValid, instrOp, wregVal, fileVal} = {1'b0, OP_MOVE_WF, 8'h00, 8'h00};
		{bitSel, srcIsFlags, destIsFlags} = '0;
		repeat (16) @(posedge core_clk);
		rst_n <= 1'b1;
		// Reset value and register access
		bus(1'b0, {24'h0, REG_FLAGS_ADDR}, 32'h0, rdata);
		check(rdata, {24'h0, FLAGS_RESET}, "reset flags");
		wr_flags(8'hFF);
		bus(1'b0, {24'h0, REG_FLAGS_ADDR}, 32'h0, rdata);
		check(rdata, 32'h0000001F, "upper bits read zero");
		bus(1'b1, 32'h00000008, 32'h000000AA, rdata);
		bus(1'b0, 32'h00000008, 32'h0, rdata);
		check(rdata, 32'h0, "unmapped read");
		$display("Test registers done");
		// Every add and subtract code against boundary operand pairs
		foreach (arithOps[i])
			foreach (pairs[j])
				run(arithOps[i], pairs[j][7:0], pairs[j][15:8], 3'h0, 1'b0, 1'b0);
		bus(1'b0, {24'h0, REG_RESULT_ADDR}, 32'h0, rdata);
		check(rdata, {24'h0, expResult}, "result readback");
		$display("Test arithmetic done");
		// Rotates through carry in both directions, both carry-in values
		for (int k = 0; k < 4; k++) begin
			wr_flags({7'h00, k[0]});
			run(k[1] ? OP_ROT_LEFT : OP_ROT_RIGHT, 8'h00, k[0] ? 8'h96 : 8'h69, 3'h0, 1'b0, 1'b0);
		end
		$display("Test rotates done");
		// Logic ops touch only negative and zero
		wr_flags(8'h0B);
		run(OP_AND, 8'hF0, 8'h0F, 3'h0, 1'b0, 1'b0);
		run(OP_IOR, 8'h80, 8'h01, 3'h0, 1'b0, 1'b0);
		run(OP_XOR, 8'h5A, 8'h5A, 3'h0, 1'b0, 1'b0);
		$display("Test logic done");
		// Ops that own no flags: untouched elsewhere, plain write into the flags
		for (int k = 0; k < 2; k++) begin
			wr_flags(8'h15);
			run(OP_BIT_CLEAR, 8'h00, 8'h00, 3'h2, 1'b1, k[0]);
			run(OP_BIT_SET, 8'h00, 8'h00, 3'h1, 1'b1, k[0]);
			run(OP_NIBBLE_SWAP, 8'h00, 8'hE3, 3'h0, 1'b0, k[0]);
			run(OP_MOVE_FF, 8'h00, 8'hFA, 3'h0, 1'b0, k[0]);
			run(OP_MOVE_WF, 8'h2C, 8'h00, 3'h0, 1'b0, k[0]);
		end
		$display("Test untouched flags done");
		// Clear of the flag register sets zero only
		wr_flags(8'h1B);
		run(OP_CLEAR_FILE, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1);
		check({24'h0, aluFlags}, 32'h0000001F, "clear keeps others");
		wr_flags(8'h0A);
		run(OP_CLEAR_FILE, 8'h00, 8'h00, 3'h0, 1'b0, 1'b1);
		check({24'h0, aluFlags}, 32'h0000000E, "clear gives zero only");
		$display("Test clear done");
		// Flag-owning op aimed at the flags: data write blocked
		wr_flags(8'h1F);
		run(OP_ADD_FILE, 8'h01, 8'h0F, 3'h0, 1'b0, 1'b1);
		check({24'h0, aluFlags}, 32'h00000002, "blocked data write");
		// Back to back: rotate sees carry from the add just before it
		issue(OP_ADD_FILE, 8'h01, 8'hFF, 3'h0, 1'b0, 1'b0);
		issue(OP_ROT_LEFT, 8'h00, 8'h40, 3'h0, 1'b0, 1'b0);
		settle();
		run(OP_MOVE_FF, 8'h00, 8'h00, 3'h0, 1'b1, 1'b0);
		@(posedge core_clk);
		#1;
		check({31'h0, resultValid}, 32'h0, "strobe one cycle");
		bus(1'b0, {24'h0, REG_FLAGS_ADDR}, 32'h0, rdata);
		check(rdata, {24'h0, expFlags}, "flags readback");
		$display("Test sequencing done");
		wrap_up();
	end
endmodule
